// File: rtl/bisu_line_edge.v
`timescale 1ns/1ps

// Synchronises the digital lines and reports their edges
module bisu_line_edge
(
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire pclk_en,
	// Asynchronous line levels
	input wire [7:0] line_in,
	// One-cycle edge pulses
	output reg [7:0] rise_pulse,
	output reg [7:0] fall_pulse
);

reg [7:0] sync1_r; // First stage, read only by second stage
reg [7:0] sync2_r; // Second stage, safe level
reg [7:0] prev_r; // Previous safe level

// Two-flop synchroniser and edge history
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		sync1_r <= 8'h00;
		sync2_r <= 8'h00;
		prev_r <= 8'h00;
		rise_pulse <= 8'h00;
		fall_pulse <= 8'h00;
	end
	else if (pclk_en)
	begin
		sync1_r <= line_in;
		sync2_r <= sync1_r;
		prev_r <= sync2_r;
		// Edges seen between two safe samples
		rise_pulse <= sync2_r & ~prev_r;
		fall_pulse <= ~sync2_r & prev_r;
	end
end

endmodule // bisu_line_edge

// File: rtl/bisu_map.vh
`ifndef BISU_MAP_VH
`define BISU_MAP_VH

// Register byte offsets inside the board window
`define BISU_OFS_FALL_EN 12'h378
`define BISU_OFS_MAIN_STAT 12'h384
`define BISU_OFS_ERR_STAT 12'h388
`define BISU_OFS_LINE_STAT 12'h38c
`define BISU_OFS_GLOBAL_CFG 12'h398
`define BISU_OFS_FRONT_PULL 12'h39c
`define BISU_OFS_REAR_PULL 12'h3a0

// Main status field positions
`define BISU_MAIN_LINE_SUM 31
`define BISU_MAIN_ERR_SUM 30
`define BISU_MAIN_FRAME_TIMER 29
`define BISU_MAIN_FRAME_TRIGGER_LINE 28
`define BISU_MAIN_IN_CONV_LO 24
`define BISU_MAIN_OUT_CONV_LO 16
`define BISU_MAIN_IN_SEQ_DONE 12
`define BISU_MAIN_IN_BUF_END_LO 8
`define BISU_MAIN_OUT_SEQ_DONE 4
`define BISU_MAIN_OUT_BUF_DONE 0

// Error status field positions
`define BISU_ERR_IN_FRAME 27
`define BISU_ERR_IN_TIMING 26
`define BISU_ERR_IN_OVERFLOW 25
`define BISU_ERR_IN_XFER 24
`define BISU_ERR_OUT_FRAME 19
`define BISU_ERR_OUT_TIMING 18
`define BISU_ERR_OUT_PRELOAD 17
`define BISU_ERR_OUT_XFER 16
`define BISU_ERR_OUT_CONV_LO 0

// Implemented (clearable) bits of each status register
`define BISU_MAIN_MASK 32'h3f03_1711
`define BISU_ERR_MASK 32'h0f0f_0003
`define BISU_LINE_MASK 32'h0000_00ff

// Global configuration fields
`define BISU_CFG_ACK_MODE 1

// Reset values
`define BISU_RST_STAT 32'h0000_0000
`define BISU_RST_FALL_EN 8'h00
`define BISU_RST_PULL 2'h0
`define BISU_RST_ACK_MODE 1'b0

`endif

// File: rtl/bisu_top.v
`timescale 1ns/1ps
`include "bisu_map.vh"

// Summary of operation
// - Latch event only when already enabled
// - Status stays until acknowledged, not by disable
// - Interrupt request while any main bit set
// - Main bit 31 ORs line status
// - Main bit 30 ORs error status
// - Bits 29/28 frame timer and trigger
// - Bits 24-27 input converter done
// - Bits 16/17 output converter updated
// - Bits 12/4 sequencer done or error
// - Bits 10:8 record input buffer end
// - Bit 0 output buffer fully fetched
// - Error bits 27/19 frame error, stop
// - Error bits 26/18 timing error, stop
// - Error bit 25 overflow, input stops
// - Error bit 17 preload fault, output stops
// - Error bits 24/16 transfer fault, engine stops
// - Error bits 0/1 output converter fault
// - Line bits 0-7 latch enabled edges
// - Falling-edge enable register, resets disabled
// - Config bit 1 picks write or read clear
// - Read clear honours byte enables
// - Two pull fields, four encodings, reset floating
module bisu_top
(
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire pclk_en,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Enables held elsewhere on the board
	input wire [31:0] main_irq_enable,
	input wire [31:0] error_irq_enable,
	input wire [7:0] line_rise_enable,
	// Main events, one-cycle pulses
	input wire frame_timer_evt,
	input wire frame_trigger_evt,
	input wire [3:0] input_conv_done_evt,
	input wire [1:0] output_conv_update_evt,
	input wire input_seq_done_evt,
	input wire output_seq_done_evt,
	input wire [2:0] input_buffer_end_evt,
	input wire output_buffer_done_evt,
	// Error events, one-cycle pulses
	input wire input_seq_frame_evt,
	input wire input_seq_timing_evt,
	input wire input_seq_overflow_evt,
	input wire input_transfer_evt,
	input wire output_seq_frame_evt,
	input wire output_seq_timing_evt,
	input wire output_seq_preload_evt,
	input wire output_transfer_evt,
	input wire [1:0] output_conv_fault_evt,
	// Digital lines, asynchronous
	input wire [7:0] digital_line,
	// Interrupt request to host
	output reg pci_irq_req,
	// Stop commands, one-cycle pulses
	output reg input_seq_stop,
	output reg output_seq_stop,
	output reg input_transfer_stop,
	output reg output_transfer_stop,
	// Pull reference selects
	output reg [1:0] front_pull_select,
	output reg [1:0] rear_pull_select
);

// Expand byte strobes into a bit mask
function [31:0] byte_mask;
	input [3:0] strb;
	begin
		byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	end
endfunction

// Sticky update: a set wins over a clear
function [31:0] sticky;
	input [31:0] cur;
	input [31:0] set;
	input [31:0] clr;
	begin
		sticky = (cur & ~clr) | set;
	end
endfunction

// Stored status and configuration
reg [31:0] main_r; // Clearable main bits
reg [31:0] err_r; // Error status
reg [31:0] line_r; // Line status
reg [7:0] fall_en_r; // Falling-edge enables
reg ack_mode_r; // 0 write clear, 1 read clear
reg [31:0] main_nxt;
reg [31:0] err_nxt;
reg [31:0] line_nxt;

// Edge pulses from the line synchroniser
wire [7:0] line_rise;
wire [7:0] line_fall;

// Line synchroniser and edge finder
bisu_line_edge u_edge
(
	.pclk(pclk),
	.presetn(presetn),
	.pclk_en(pclk_en),
	.line_in(digital_line),
	.rise_pulse(line_rise),
	.fall_pulse(line_fall)
);

// Bus phase decode
wire setup_ph = psel & ~penable; // Setup cycle
wire access_ph = psel & penable & pclk_en; // Access completes
wire wr_done = access_ph & pwrite; // Write takes effect
wire rd_done = access_ph & ~pwrite; // Read completes
wire [31:0] strb_mask = byte_mask(pstrb); // Write lanes
// Read lanes: all bytes when the master leaves strobes low
wire [31:0] rd_mask = (pstrb == 4'h0) ? 32'hffff_ffff : strb_mask;

// Address hits
wire hit_fall = (paddr == `BISU_OFS_FALL_EN);
wire hit_main = (paddr == `BISU_OFS_MAIN_STAT);
wire hit_err = (paddr == `BISU_OFS_ERR_STAT);
wire hit_line = (paddr == `BISU_OFS_LINE_STAT);
wire hit_cfg = (paddr == `BISU_OFS_GLOBAL_CFG);
wire hit_front = (paddr == `BISU_OFS_FRONT_PULL);
wire hit_rear = (paddr == `BISU_OFS_REAR_PULL);
wire hit_any = hit_fall | hit_main | hit_err | hit_line | hit_cfg | hit_front | hit_rear;

// Zero-wait slave; frozen while the clock enable is low
assign pready = pclk_en;
// Unmapped addresses answer with an error
assign pslverr = psel & penable & ~hit_any;

// Read view of the main register with live summaries
reg [31:0] main_view;
always @*
begin
	main_view = main_r;
	main_view[`BISU_MAIN_LINE_SUM] = |line_r;
	main_view[`BISU_MAIN_ERR_SUM] = |err_r;
end

// Raw main events placed at their bit positions
reg [31:0] main_evt;
always @*
begin
	main_evt = 32'h0000_0000;
	main_evt[`BISU_MAIN_FRAME_TIMER] = frame_timer_evt;
	main_evt[`BISU_MAIN_FRAME_TRIGGER_LINE] = frame_trigger_evt;
	main_evt[`BISU_MAIN_IN_CONV_LO +: 4] = input_conv_done_evt;
	main_evt[`BISU_MAIN_OUT_CONV_LO +: 2] = output_conv_update_evt;
	// done, also on frame or timing error, plus overflow (input) or preload (output)
	main_evt[`BISU_MAIN_IN_SEQ_DONE] = input_seq_done_evt | input_seq_frame_evt
		| input_seq_timing_evt | input_seq_overflow_evt;
	main_evt[`BISU_MAIN_OUT_SEQ_DONE] = output_seq_done_evt | output_seq_frame_evt
		| output_seq_timing_evt | output_seq_preload_evt;
	main_evt[`BISU_MAIN_IN_BUF_END_LO +: 3] = input_buffer_end_evt;
	main_evt[`BISU_MAIN_OUT_BUF_DONE] = output_buffer_done_evt;
end

// Raw error events placed at their bit positions
reg [31:0] err_evt;
always @*
begin
	err_evt = 32'h0000_0000;
	err_evt[`BISU_ERR_IN_FRAME] = input_seq_frame_evt;
	err_evt[`BISU_ERR_OUT_FRAME] = output_seq_frame_evt;
	err_evt[`BISU_ERR_IN_TIMING] = input_seq_timing_evt;
	err_evt[`BISU_ERR_OUT_TIMING] = output_seq_timing_evt;
	err_evt[`BISU_ERR_IN_OVERFLOW] = input_seq_overflow_evt;
	err_evt[`BISU_ERR_OUT_PRELOAD] = output_seq_preload_evt;
	err_evt[`BISU_ERR_IN_XFER] = input_transfer_evt;
	err_evt[`BISU_ERR_OUT_XFER] = output_transfer_evt;
	err_evt[`BISU_ERR_OUT_CONV_LO +: 2] = output_conv_fault_evt;
end

// only enabled events reach the status
wire [31:0] main_set = main_evt & main_irq_enable & `BISU_MAIN_MASK;
wire [31:0] err_set = err_evt & error_irq_enable & `BISU_ERR_MASK;
// rising and falling enables pick the edges
wire [31:0] line_set = {24'h00_0000, (line_rise & line_rise_enable) | (line_fall & fall_en_r)};

// Clear masks for each status register
reg [31:0] main_clr;
reg [31:0] err_clr;
reg [31:0] line_clr;
always @*
begin
	main_clr = 32'h0000_0000;
	err_clr = 32'h0000_0000;
	line_clr = 32'h0000_0000;
	// write one to clear in write mode
	if (wr_done && !ack_mode_r)
	begin
		if (hit_main)
			main_clr = pwdata & strb_mask;
		else if (hit_err)
			err_clr = pwdata & strb_mask;
		else if (hit_line)
			line_clr = pwdata & strb_mask;
	end
	// read clears only reported bits in read lanes
	else if (rd_done && ack_mode_r)
	begin
		if (hit_main)
			main_clr = prdata & rd_mask;
		else if (hit_err)
			err_clr = prdata & rd_mask;
		else if (hit_line)
			line_clr = prdata & rd_mask;
	end
end

// Next status values; set wins over clear
always @*
begin
	// only acknowledge clears, never a disable
	main_nxt = sticky(main_r, main_set, main_clr) & `BISU_MAIN_MASK;
	err_nxt = sticky(err_r, err_set, err_clr) & `BISU_ERR_MASK;
	line_nxt = sticky(line_r, line_set, line_clr) & `BISU_LINE_MASK;
end

// Status registers and interrupt request
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		main_r <= `BISU_RST_STAT;
		err_r <= `BISU_RST_STAT;
		line_r <= `BISU_RST_STAT;
		pci_irq_req <= 1'b0;
	end
	else if (pclk_en)
	begin
		main_r <= main_nxt;
		err_r <= err_nxt;
		line_r <= line_nxt;
		// request follows any main bit, summaries included
		pci_irq_req <= (|main_nxt) | (|err_nxt) | (|line_nxt);
	end
end

// Stop commands to sequencers and transfer engines
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		input_seq_stop <= 1'b0;
		output_seq_stop <= 1'b0;
		input_transfer_stop <= 1'b0;
		output_transfer_stop <= 1'b0;
	end
	else if (pclk_en)
	begin
		input_seq_stop <= input_seq_frame_evt | input_seq_timing_evt | input_seq_overflow_evt;
		output_seq_stop <= output_seq_frame_evt | output_seq_timing_evt
			| output_seq_preload_evt;
		input_transfer_stop <= input_transfer_evt;
		output_transfer_stop <= output_transfer_evt;
	end
end

// Configuration registers written over the bus
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		fall_en_r <= `BISU_RST_FALL_EN;
		ack_mode_r <= `BISU_RST_ACK_MODE;
		front_pull_select <= `BISU_RST_PULL;
		rear_pull_select <= `BISU_RST_PULL;
	end
	else if (wr_done && pstrb[0])
	begin
		// only low implemented bits are stored
		if (hit_fall)
			fall_en_r <= pwdata[7:0];
		else if (hit_cfg)
			ack_mode_r <= pwdata[`BISU_CFG_ACK_MODE];
		// 00 float, 01 5 V, 10 3.3 V, 11 ground
		else if (hit_front)
			front_pull_select <= pwdata[1:0];
		else if (hit_rear)
			rear_pull_select <= pwdata[1:0];
	end
end

// Read data multiplexer
reg [31:0] rd_val;
always @*
begin
	rd_val = 32'h0000_0000;
	if (hit_fall)
		rd_val = {24'h00_0000, fall_en_r};
	else if (hit_main)
		rd_val = main_view;
	else if (hit_err)
		rd_val = err_r;
	else if (hit_line)
		rd_val = line_r;
	else if (hit_cfg)
		rd_val = {30'h0000_0000, ack_mode_r, 1'b0};
	else if (hit_front)
		rd_val = {30'h0000_0000, front_pull_select};
	else if (hit_rear)
		rd_val = {30'h0000_0000, rear_pull_select};
end

// Read data captured in the setup cycle
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		prdata <= 32'h0000_0000;
	else if (pclk_en && setup_ph && !pwrite)
		prdata <= rd_val;
end

endmodule // bisu_top

// File: test/bisu_host.sv
`timescale 1ns/1ps

// Host end of the request line, counts assertions
module bisu_host
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Level request from the board
	input wire pci_irq_req,
	// Rising edges seen so far
	output reg [7:0] irq_seen
);
	// Previous level of the request
	reg last_r;

	// Counts each new assertion of the level request
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_seen <= 8'h00;
			last_r <= 1'b0;
		end
		else
		begin
			last_r <= pci_irq_req;
			if (pci_irq_req && !last_r)
				irq_seen <= irq_seen + 8'h01;
		end
	end
endmodule // bisu_host

// File: test/bisu_top_properties.sv
`timescale 1ns/1ps

// Pin-level checks of the status unit
module bisu_chk
(
	// Clock, reset, enable
	input wire pclk,
	input wire presetn,
	input wire pclk_en,
	// Bus
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire pslverr,
	// Enables and events
	input wire [31:0] main_irq_enable,
	input wire [31:0] error_irq_enable,
	input wire frame_timer_evt,
	input wire [1:0] output_conv_fault_evt,
	input wire input_seq_frame_evt,
	input wire output_seq_timing_evt,
	input wire input_transfer_evt,
	input wire output_transfer_evt,
	// Outputs
	input wire pci_irq_req,
	input wire input_seq_stop,
	input wire output_seq_stop,
	input wire input_transfer_stop,
	input wire output_transfer_stop,
	input wire [1:0] front_pull_select
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Completed bus access
	sequence s_acc;
		psel && penable && pclk_en;
	endsequence
	// Request up one cycle later
	sequence s_req;
		##1 pci_irq_req;
	endsequence

	property p_tim; frame_timer_evt && main_irq_enable[29] && pclk_en |-> s_req; endproperty
	property p_flt; output_conv_fault_evt[1] && error_irq_enable[1] && pclk_en |-> s_req;
	endproperty
	property p_hold; pci_irq_req && !psel && pclk_en |=> pci_irq_req; endproperty
	property p_istop; input_seq_frame_evt && pclk_en |=> input_seq_stop; endproperty
	property p_ostop; output_seq_timing_evt && pclk_en |=> output_seq_stop; endproperty
	property p_xstop; input_transfer_evt && pclk_en |=> input_transfer_stop; endproperty
	property p_oxstop; output_transfer_evt && pclk_en |=> output_transfer_stop; endproperty
	property p_unmap; s_acc ##0 (paddr == 12'h3fc) |-> pslverr; endproperty
	property p_pull; !(psel && penable && pwrite) |=> $stable(front_pull_select); endproperty

	a_tim: assert property (p_tim) else $error("frame timer event lost");
	a_flt: assert property (p_flt) else $error("converter fault lost");
	a_hold: assert property (p_hold) else $error("request dropped");
	a_istop: assert property (p_istop) else $error("input stop missing");
	a_ostop: assert property (p_ostop) else $error("output stop missing");
	a_xstop: assert property (p_xstop) else $error("transfer stop missing");
	a_oxstop: assert property (p_oxstop) else $error("output transfer stop missing");
	a_unmap: assert property (p_unmap) else $error("unmapped not refused");
	a_pull: assert property (p_pull) else $error("pull select moved");
endmodule // bisu_chk

bind bisu_top bisu_chk u_chk (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
	.main_irq_enable(main_irq_enable), .error_irq_enable(error_irq_enable),
	.frame_timer_evt(frame_timer_evt), .output_conv_fault_evt(output_conv_fault_evt),
	.input_seq_frame_evt(input_seq_frame_evt), .output_seq_timing_evt(output_seq_timing_evt),
	.input_transfer_evt(input_transfer_evt), .output_transfer_evt(output_transfer_evt),
	.pci_irq_req(pci_irq_req),
	.input_seq_stop(input_seq_stop), .output_seq_stop(output_seq_stop),
	.input_transfer_stop(input_transfer_stop), .output_transfer_stop(output_transfer_stop),
	.front_pull_select(front_pull_select));

// File: test/bisu_top_tb.sv
`timescale 1ns/1ps
`include "bisu_map.vh"

// Self-checking bench of the status unit
module bisu_top_tb;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cen = 1;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, men = 0, een = 0, mev = 0, eev = 0, rd;
	reg [3:0] pstrb = 0;
	reg [7:0] ren = 0, dl = 0;
	wire [31:0] prdata;
	wire [7:0] seen;
	wire [1:0] fp, rp;
	wire pready, pslverr, irq, iss, oss, its, ots;
	integer miscompares = 0, n_checks = 0, k;

	// Clock, 100 ns period
	always #50 pclk = ~pclk;

	bisu_top u_dut (.pclk(pclk), .presetn(presetn), .pclk_en(cen), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .main_irq_enable(men),
		.error_irq_enable(een), .line_rise_enable(ren), .frame_timer_evt(mev[29]),
		.frame_trigger_evt(mev[28]), .input_conv_done_evt(mev[27:24]),
		.output_conv_update_evt(mev[17:16]), .input_seq_done_evt(mev[12]),
		.output_seq_done_evt(mev[4]), .input_buffer_end_evt(mev[10:8]),
		.output_buffer_done_evt(mev[0]), .input_seq_frame_evt(eev[27]),
		.input_seq_timing_evt(eev[26]), .input_seq_overflow_evt(eev[25]),
		.input_transfer_evt(eev[24]), .output_seq_frame_evt(eev[19]),
		.output_seq_timing_evt(eev[18]), .output_seq_preload_evt(eev[17]),
		.output_transfer_evt(eev[16]), .output_conv_fault_evt(eev[1:0]), .digital_line(dl),
		.pci_irq_req(irq), .input_seq_stop(iss), .output_seq_stop(oss),
		.input_transfer_stop(its), .output_transfer_stop(ots), .front_pull_select(fp),
		.rear_pull_select(rp));

	bisu_host u_host (.pclk(pclk), .presetn(presetn), .pci_irq_req(irq), .irq_seen(seen));

	// Verdict and end of run
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	// One comparison
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e)
			begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0t got %h exp %h", $time, g, e);
			end
		end
	endtask

	// One APB transfer, read data left in rd
	task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
		integer i;
		begin
			@(posedge pclk);
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			pstrb <= s;
			@(posedge pclk);
			penable <= 1;
			i = 0;
			@(posedge pclk);
			// Bounded wait for ready
			while (pready !== 1'b1 && i < 20)
			begin
				@(posedge pclk);
				i = i + 1;
			end
			if (i == 20)
			begin
				miscompares = miscompares + 1;
				finish_test;
			end
			rd = prdata;
			psel <= 0;
			penable <= 0;
		end
	endtask

	// Read a word and compare
	task chk_rd(input [11:0] a, input [31:0] e);
		begin
			apb(0, a, 32'h0000_0000, 4'hf);
			chk(rd, e);
		end
	endtask

	// One-cycle event pulses
	task pulse(input [31:0] m, input [31:0] e);
		begin
			@(posedge pclk);
			mev <= m;
			eev <= e;
			@(posedge pclk);
			mev <= 0;
			eev <= 0;
			@(posedge pclk);
		end
	endtask

	// Reset values and an unmapped place
	task t_reset;
		begin
			chk_rd(`BISU_OFS_FALL_EN, 0);
			chk_rd(`BISU_OFS_MAIN_STAT, 0);
			chk_rd(`BISU_OFS_GLOBAL_CFG, 0);
			chk_rd(`BISU_OFS_FRONT_PULL, 0);
			chk_rd(`BISU_OFS_REAR_PULL, 0);
			apb(1, 12'h3fc, 32'hffff_ffff, 4'hf);
			chk_rd(12'h3fc, 0);
		end
	endtask

	// Enable gating, holding, write-one clear
	task t_enable;
		begin
			pulse(32'h2000_0000, 0);
			chk_rd(`BISU_OFS_MAIN_STAT, 0);
			men <= 32'hffff_ffff;
			pulse(32'h2000_0000, 0);
			chk({31'h0, irq}, 1);
			men <= 0;
			chk_rd(`BISU_OFS_MAIN_STAT, 32'h2000_0000);
			apb(1, `BISU_OFS_MAIN_STAT, 32'h2000_0000, 4'hf);
			// Request drops at the access edge, look one edge later
			@(posedge pclk);
			chk({31'h0, irq}, 0);
			chk_rd(`BISU_OFS_MAIN_STAT, 0);
		end
	endtask

	// Every main source at once
	task t_main;
		begin
			men <= 32'hffff_ffff;
			pulse(`BISU_MAIN_MASK, 0);
			chk_rd(`BISU_OFS_MAIN_STAT, 32'h3f03_1711);
			apb(1, `BISU_OFS_MAIN_STAT, 32'hffff_ffff, 4'hf);
			chk_rd(`BISU_OFS_MAIN_STAT, 0);
		end
	endtask

	// Every error source, summary bit and done bits
	task t_err;
		begin
			een <= 32'hffff_ffff;
			pulse(0, `BISU_ERR_MASK);
			chk_rd(`BISU_OFS_ERR_STAT, 32'h0f0f_0003);
			chk_rd(`BISU_OFS_MAIN_STAT, 32'h4000_1010);
			apb(1, `BISU_OFS_ERR_STAT, 32'hffff_ffff, 4'hf);
			chk_rd(`BISU_OFS_MAIN_STAT, 32'h0000_1010);
			apb(1, `BISU_OFS_MAIN_STAT, 32'hffff_ffff, 4'hf);
		end
	endtask

	// Line edges per edge enables
	task t_line;
		begin
			apb(1, `BISU_OFS_FALL_EN, 32'hffff_ffff, 4'hf);
			chk_rd(`BISU_OFS_FALL_EN, 32'h0000_00ff);
			ren <= 8'h0f;
			dl <= 8'hff;
			repeat (8) @(posedge pclk);
			chk_rd(`BISU_OFS_LINE_STAT, 32'h0000_000f);
			dl <= 8'h00;
			repeat (8) @(posedge pclk);
			chk_rd(`BISU_OFS_LINE_STAT, 32'h0000_00ff);
			chk_rd(`BISU_OFS_MAIN_STAT, 32'h8000_0000);
			apb(1, `BISU_OFS_LINE_STAT, 32'h0000_00ff, 4'hf);
			chk_rd(`BISU_OFS_MAIN_STAT, 0);
		end
	endtask

	// Clear-on-read by byte lanes
	task t_cor;
		begin
			apb(1, `BISU_OFS_GLOBAL_CFG, 32'h0000_0002, 4'hf);
			chk_rd(`BISU_OFS_GLOBAL_CFG, 32'h0000_0002);
			pulse(32'h3000_0001, 0);
			apb(0, `BISU_OFS_MAIN_STAT, 0, 4'h8);
			chk(rd, 32'h3000_0001);
			chk_rd(`BISU_OFS_MAIN_STAT, 32'h0000_0001);
			chk_rd(`BISU_OFS_MAIN_STAT, 0);
			chk({31'h0, irq}, 0);
			apb(1, `BISU_OFS_GLOBAL_CFG, 0, 4'hf);
		end
	endtask

	// All four pull codes on both fields
	task t_pull;
		begin
			for (k = 0; k < 4; k = k + 1)
			begin
				apb(1, `BISU_OFS_FRONT_PULL, 32'hffff_fffc | k, 4'hf);
				apb(1, `BISU_OFS_REAR_PULL, 32'h0000_0003 - k, 4'hf);
				// Selects change at the access edge, look one edge later
				@(posedge pclk);
				chk({30'h0, fp}, k);
				chk({30'h0, rp}, 3 - k);
				chk_rd(`BISU_OFS_FRONT_PULL, k);
			end
		end
	endtask

	// Low clock enable freezes state, event is dropped
	task t_freeze;
		begin
			cen <= 0;
			pulse(32'h2000_0000, 0);
			cen <= 1;
			chk({31'h0, irq}, 0);
			chk_rd(`BISU_OFS_MAIN_STAT, 0);
		end
	endtask

	// Watchdog on the whole run
	initial
	begin
		repeat (20000) @(posedge pclk);
		miscompares = miscompares + 1;
		finish_test;
	end

	// Main sequence
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_enable;
		t_main;
		t_err;
		t_line;
		t_cor;
		t_pull;
		t_freeze;
		chk({24'h0, seen}, 5);
		finish_test;
	end
endmodule // bisu_top_tb
